// [pkg/serial_channel_one_params.svh]
// offsets, field positions, reset values and timing counts of the second serial channel
`ifndef SERIAL_CHANNEL_ONE_PARAMS_SVH
`define SERIAL_CHANNEL_ONE_PARAMS_SVH
// register byte addresses
`define SC1_OFS_TX_CTRL  8'h00
`define SC1_OFS_RX_CTRL  8'h04
`define SC1_OFS_DATA     8'h08
`define SC1_OFS_STATUS   8'h0C
// reset values as read back, and masks of the bits that really exist
`define SC1_TX_CTRL_RST  8'h88
`define SC1_RX_CTRL_RST  8'h08
`define SC1_STATUS_RST   8'h00
`define SC1_TX_CTRL_IMPL 8'h77
`define SC1_RX_CTRL_IMPL 8'hF7
// control register fields, shared by both directions except REN, which only the receive side implements
`define SC1_B_MULTI      0
`define SC1_B_SYNC       1
`define SC1_B_ADDR       2
`define SC1_B_STB_MST    4
`define SC1_B_PEN        5
`define SC1_B_EVN        6
`define SC1_B_REN        7
// status register fields
`define SC1_B_FERR       0
`define SC1_B_OERR       1
`define SC1_B_PERR       2
`define SC1_B_MERR       3
`define SC1_B_RXIE       4
`define SC1_B_RXIRQ      5
`define SC1_B_TXIE       6
`define SC1_B_TXIRQ      7
// clock cycles per serial bit
`define SC1_BIT_CYCLES   16
// axi responses
`define SC1_RESP_OKAY    2'h0
`define SC1_RESP_SLVERR  2'h2
`endif

// [pkg/serial_channel_one_pkg.sv]
// types of the serial channel design, used by serial_channel_one
package serial_channel_one_pkg;
  // position within one serial frame, used by both shifters
  typedef enum logic [2:0] {ph_idle, ph_start, ph_data, ph_mark, ph_parity, ph_stop} phase_t;
endpackage : serial_channel_one_pkg

// [verilog/pin_sync3.sv]
// three-stage synchroniser with agreement filter for an asynchronous pin
module pin_sync3 #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // the level only moves once the second and third stage agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q    <= RESET_VAL;
      s2_q    <= RESET_VAL;
      s3_q    <= RESET_VAL;
      level_q <= RESET_VAL;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        level_q <= s3_q;
    end
  end

  assign level = level_q;
endmodule : pin_sync3

// [verilog/bit_timer.sv]
// free running bit period counter, restartable at a half or full period
module bit_timer #(
  parameter int unsigned CYCLES = 16
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic restart,
  input  wire logic half,
  output logic      tick
);
  localparam int unsigned W = $clog2(CYCLES + 1);
  logic [W-1:0] count_q;

  if (CYCLES < 2)
  begin : g_bad
    $error("bit_timer needs at least two cycles per period");
  end

  // reload on zero so a running frame sees evenly spaced ticks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_q <= '0;
    else if (restart)
      count_q <= half ? W'(CYCLES / 2 - 1) : W'(CYCLES - 1);
    else if (count_q == '0)
      count_q <= W'(CYCLES - 1);
    else
      count_q <= count_q - 1'b1;
  end

  assign tick = (count_q == '0) && !restart;
endmodule : bit_timer

// [verilog/serial_channel_one.sv]
// second serial channel: uart / synchronous shifters behind an axi4-lite register slave
`include "serial_channel_one_params.svh"
module serial_channel_one #(
  parameter int unsigned BIT_CYCLES = `SC1_BIT_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe_n,
  output logic             rx_irq,
  output logic             tx_irq
);
  import serial_channel_one_pkg::*;

  if (BIT_CYCLES < 4)
  begin : g_bad
    $error("BIT_CYCLES must be at least 4");
  end

  logic       awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] awaddr_q, wdata_q;
  logic       wstrb0_q, aw_held_q, w_held_q;
  logic [7:0] tx_ctrl_q, rx_ctrl_q, status_q, tx_hold_q, rx_hold_q;
  logic [7:0] tx_shift_q, rx_shift_q;
  logic [2:0] tx_cnt_q, rx_cnt_q;
  phase_t     tx_ph_q, rx_ph_q, tx_next, rx_next;
  logic       txd_q, tx_par_q, tx_full_q;
  logic       rx_mark_q, rx_pbit_q, rx_stop_q, rx_end_q, rx_unread_q;
  logic       sclk_q, sclk_oe_n_q, sclk_prev_q, rx_irq_q, tx_irq_q;
  logic       rxd_lvl, sclk_lvl, tx_tick, rx_tick, gen_tick;

  // field decode; bit 4 means stop length in uart and role in synchronous mode
  wire tx_multi  = tx_ctrl_q[`SC1_B_MULTI];
  wire tx_sync   = tx_ctrl_q[`SC1_B_SYNC];
  wire tx_stop1  = !tx_sync && tx_ctrl_q[`SC1_B_STB_MST];
  wire tx_master = tx_sync && tx_ctrl_q[`SC1_B_STB_MST];
  wire rx_multi  = rx_ctrl_q[`SC1_B_MULTI];
  wire rx_sync   = rx_ctrl_q[`SC1_B_SYNC];
  wire rx_master = rx_sync && rx_ctrl_q[`SC1_B_STB_MST];
  wire rx_en     = rx_ctrl_q[`SC1_B_REN];
  wire [7:0] tx_ctrl_view = tx_ctrl_q | ~`SC1_TX_CTRL_IMPL;
  wire [7:0] rx_ctrl_view = rx_ctrl_q | ~`SC1_RX_CTRL_IMPL;

  // frame sequence: start (uart), 8 data, address marker, parity, stop (uart)
  function automatic phase_t after_phase(input phase_t cur, input logic multi, input logic pen,
                                         input logic uart);
    phase_t n;
    n = ph_idle;
    case (cur)
      ph_start:  n = ph_data;
      ph_data:   n = multi ? ph_mark : pen ? ph_parity : uart ? ph_stop : ph_idle;
      ph_mark:   n = pen ? ph_parity : uart ? ph_stop : ph_idle;
      ph_parity: n = uart ? ph_stop : ph_idle;
      default:   n = ph_idle;
    endcase
    return n;
  endfunction : after_phase

  assign tx_next = after_phase(tx_ph_q, tx_multi, tx_ctrl_q[`SC1_B_PEN], !tx_sync);
  assign rx_next = after_phase(rx_ph_q, rx_multi, rx_ctrl_q[`SC1_B_PEN], !rx_sync);

  // pins from the far side pass the filtered synchroniser
  pin_sync3 #(.RESET_VAL(1'b1)) u_rxd_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (rxd),
    .level   (rxd_lvl)
  );
  pin_sync3 #(.RESET_VAL(1'b0)) u_sclk_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (sclk_in),
    .level   (sclk_lvl)
  );

  // bit timers: uart transmit, uart receive (mid-bit), synchronous clock halves
  bit_timer #(.CYCLES(BIT_CYCLES)) u_tx_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (tx_ph_q == ph_idle),
    .half    (1'b0),
    .tick    (tx_tick)
  );
  bit_timer #(.CYCLES(BIT_CYCLES)) u_rx_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (rx_ph_q == ph_idle),
    .half    (1'b1),
    .tick    (rx_tick)
  );
  wire sclk_run = (tx_master && tx_ph_q != ph_idle) || (rx_master && rx_en);
  bit_timer #(.CYCLES(BIT_CYCLES / 2)) u_sclk_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (!sclk_run),
    .half    (1'b0),
    .tick    (gen_tick)
  );

  // shift clock: master drives only while running and idles low and released; slave follows the filtered pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sclk_q      <= 1'b0;
      sclk_oe_n_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      sclk_q      <= sclk_run ? (sclk_q ^ gen_tick) : 1'b0;
      sclk_oe_n_q <= !sclk_run;
      sclk_prev_q <= sclk_lvl;
    end
  end
  wire gen_rise = sclk_run && gen_tick && !sclk_q;
  wire gen_fall = sclk_run && gen_tick && sclk_q;
  wire slv_rise = sclk_lvl && !sclk_prev_q;
  wire slv_fall = !sclk_lvl && sclk_prev_q;
  // data moves on the falling edge and is sampled on the rising edge
  wire tx_step  = tx_sync ? (tx_master ? gen_fall : slv_fall) : tx_tick;
  wire rx_step  = rx_sync ? (rx_master ? gen_rise : slv_rise) : rx_tick;

  // axi write channel: address and data taken in either order, response after both
  wire aw_take  = awvalid && awready_q;
  wire w_take   = wvalid && wready_q;
  wire wr_fire  = aw_held_q && w_held_q && !bvalid_q;
  wire aw_held_n = (aw_held_q || aw_take) && !wr_fire;
  wire w_held_n  = (w_held_q || w_take) && !wr_fire;
  wire bvalid_n  = wr_fire || (bvalid_q && !bready);
  wire wr_en    = wr_fire && wstrb0_q;
  wire wr_tx    = wr_en && awaddr_q == `SC1_OFS_TX_CTRL;
  wire wr_rx    = wr_en && awaddr_q == `SC1_OFS_RX_CTRL;
  wire wr_data  = wr_en && awaddr_q == `SC1_OFS_DATA;
  wire wr_stat  = wr_en && awaddr_q == `SC1_OFS_STATUS;
  wire wr_hit   = awaddr_q == `SC1_OFS_TX_CTRL || awaddr_q == `SC1_OFS_RX_CTRL ||
                  awaddr_q == `SC1_OFS_DATA || awaddr_q == `SC1_OFS_STATUS;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `SC1_RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
    end
    else
    begin
      aw_held_q <= aw_held_n;
      w_held_q  <= w_held_n;
      bvalid_q  <= bvalid_n;
      awready_q <= !aw_held_n && !bvalid_n;
      wready_q  <= !w_held_n && !bvalid_n;
      if (aw_take)
        awaddr_q <= awaddr;
      if (w_take)
      begin
        wdata_q  <= wdata[7:0];
        wstrb0_q <= wstrb[0];
      end
      if (wr_fire)
        bresp_q <= wr_hit ? `SC1_RESP_OKAY : `SC1_RESP_SLVERR;
    end
  end

  // axi read channel: data answered the cycle after the address is taken
  wire ar_take  = arvalid && arready_q;
  wire rvalid_n = ar_take || (rvalid_q && !rready);
  wire rd_data  = ar_take && araddr == `SC1_OFS_DATA;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `SC1_RESP_OKAY;
    end
    else
    begin
      arready_q <= !rvalid_n;
      rvalid_q  <= rvalid_n;
      if (ar_take)
      begin
        rresp_q <= `SC1_RESP_OKAY;
        case (araddr)
          `SC1_OFS_TX_CTRL: rdata_q <= {24'h000000, tx_ctrl_view};
          `SC1_OFS_RX_CTRL: rdata_q <= {24'h000000, rx_ctrl_view};
          `SC1_OFS_DATA:    rdata_q <= {24'h000000, rx_hold_q};
          `SC1_OFS_STATUS:  rdata_q <= {24'h000000, status_q};
          default:
          begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= `SC1_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // control registers; aresetn loads the reset values masked to the implemented bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_ctrl_q <= `SC1_TX_CTRL_RST & `SC1_TX_CTRL_IMPL;
      rx_ctrl_q <= `SC1_RX_CTRL_RST & `SC1_RX_CTRL_IMPL;
    end
    else
    begin
      // changes mid-frame take effect at once, so software must wait for idle
      if (wr_tx)
        tx_ctrl_q <= wdata_q & `SC1_TX_CTRL_IMPL;
      if (wr_rx)
        rx_ctrl_q <= wdata_q & `SC1_RX_CTRL_IMPL;
    end
  end

  // transmit holding register; a write while full overwrites the waiting byte
  wire tx_load = (tx_ph_q == ph_idle) && tx_full_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_hold_q <= 8'h00;
      tx_full_q <= 1'b0;
    end
    else
    begin
      if (wr_data)
        tx_hold_q <= wdata_q;
      tx_full_q <= wr_data || (tx_full_q && !tx_load);
    end
  end

  // transmit shifter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_ph_q    <= ph_idle;
      tx_shift_q <= 8'h00;
      tx_cnt_q   <= 3'd0;
      txd_q      <= 1'b1;
      tx_par_q   <= 1'b0;
    end
    else if (tx_ph_q == ph_idle)
    begin
      if (tx_full_q)
      begin
        tx_shift_q <= tx_hold_q;
        tx_par_q   <= ^tx_hold_q ^ !tx_ctrl_q[`SC1_B_EVN];
        tx_cnt_q   <= 3'd0;
        tx_ph_q    <= tx_sync ? ph_data : ph_start;
        txd_q      <= tx_sync ? tx_hold_q[0] : 1'b0;
      end
    end
    else if (tx_step)
    begin
      if (tx_ph_q == ph_data && tx_cnt_q != 3'd7)
      begin
        tx_cnt_q   <= tx_cnt_q + 3'd1;
        tx_shift_q <= {1'b0, tx_shift_q[7:1]};
        txd_q      <= tx_shift_q[1];
      end
      else if (tx_ph_q == ph_stop && tx_cnt_q == 3'd0 && !tx_stop1)
        tx_cnt_q <= 3'd1;
      else
      begin
        tx_ph_q  <= tx_next;
        tx_cnt_q <= 3'd0;
        case (tx_next)
          ph_data:   txd_q <= tx_shift_q[0];
          ph_mark:   txd_q <= tx_ctrl_q[`SC1_B_ADDR];
          ph_parity: txd_q <= tx_par_q;
          default:   txd_q <= 1'b1;
        endcase
      end
    end
  end

  // receive shifter; dropping the enable abandons the frame in progress
  wire rx_last = rx_step && rx_ph_q != ph_idle && rx_ph_q != ph_start && rx_next == ph_idle &&
                 (rx_ph_q != ph_data || rx_cnt_q == 3'd7);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_ph_q    <= ph_idle;
      rx_shift_q <= 8'h00;
      rx_cnt_q   <= 3'd0;
      rx_mark_q  <= 1'b0;
      rx_pbit_q  <= 1'b0;
      rx_stop_q  <= 1'b1;
      rx_end_q   <= 1'b0;
    end
    else
    begin
      rx_end_q <= rx_en && rx_last;
      if (!rx_en)
        rx_ph_q <= ph_idle;
      else if (rx_ph_q == ph_idle)
      begin
        rx_cnt_q  <= 3'd0;
        rx_mark_q <= 1'b0;
        rx_stop_q <= 1'b1;
        if (rx_sync)
          rx_ph_q <= ph_data;
        else if (!rxd_lvl)
          rx_ph_q <= ph_start;
      end
      else if (rx_step)
      begin
        case (rx_ph_q)
          ph_start:  rx_ph_q <= rxd_lvl ? ph_idle : ph_data;          // glitch is no start
          ph_data:
          begin
            rx_shift_q <= {rxd_lvl, rx_shift_q[7:1]};
            rx_cnt_q   <= rx_cnt_q + 3'd1;
            if (rx_cnt_q == 3'd7)
              rx_ph_q <= rx_next;
          end
          ph_mark:
          begin
            rx_mark_q <= rxd_lvl;
            rx_ph_q   <= rx_next;
          end
          ph_parity:
          begin
            rx_pbit_q <= rxd_lvl;
            rx_ph_q   <= rx_next;
          end
          default:
          begin
            rx_stop_q <= rxd_lvl;
            rx_ph_q   <= ph_idle;
          end
        endcase
      end
    end
  end

  // end of reception: filter, then load the one holding register and the flags
  wire rx_addr_wait = rx_multi && rx_ctrl_q[`SC1_B_ADDR];
  wire rx_ignore = rx_addr_wait && !rx_mark_q;
  wire rx_accept = rx_end_q && !rx_ignore;
  wire rx_perr   = rx_ctrl_q[`SC1_B_PEN] &&
                   (rx_pbit_q != (^rx_shift_q ^ !rx_ctrl_q[`SC1_B_EVN]));
  wire rx_merr   = rx_multi && !rx_ctrl_q[`SC1_B_ADDR] && rx_mark_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_hold_q   <= 8'h00;
      rx_unread_q <= 1'b0;
    end
    else
    begin
      if (rx_accept)
        rx_hold_q <= rx_shift_q;
      rx_unread_q <= rx_accept || (rx_unread_q && !rd_data);
    end
  end

  // status: software writes, hardware sets; a set in the same cycle wins
  wire [7:0] stat_set = {tx_load, 1'b0, rx_accept, 1'b0,
                         rx_accept && rx_merr, rx_accept && rx_perr,
                         rx_accept && rx_unread_q,
                         rx_accept && !rx_stop_q};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_q <= `SC1_STATUS_RST;
    else
      status_q <= (wr_stat ? wdata_q : status_q) | stat_set;
  end

  // request lines toward the interrupt controller
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_irq_q <= 1'b0;
      tx_irq_q <= 1'b0;
    end
    else
    begin
      rx_irq_q <= status_q[`SC1_B_RXIRQ] && status_q[`SC1_B_RXIE];
      tx_irq_q <= status_q[`SC1_B_TXIRQ] && status_q[`SC1_B_TXIE];
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign txd     = txd_q;
  assign sclk_out  = sclk_q;
  assign sclk_oe_n = sclk_oe_n_q;
  assign rx_irq  = rx_irq_q;
  assign tx_irq  = tx_irq_q;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_tx_rst;    $rose(aresetn) |-> tx_ctrl_view == `SC1_TX_CTRL_RST; endproperty
  property p_rx_rst;    $rose(aresetn) |-> rx_ctrl_view == `SC1_RX_CTRL_RST; endproperty
  property p_stat_rst;  $rose(aresetn) |-> status_q == `SC1_STATUS_RST; endproperty
  property p_rx_load;   rx_accept |=> rx_hold_q == $past(rx_shift_q) && status_q[`SC1_B_RXIRQ]; endproperty
  property p_rx_ignore; rx_end_q && rx_ignore |=> rx_hold_q == $past(rx_hold_q); endproperty
  property p_sticky;    status_q[`SC1_B_FERR] && !wr_stat |=> status_q[`SC1_B_FERR]; endproperty
  property p_overrun;   rx_accept && rx_unread_q |=> status_q[`SC1_B_OERR]; endproperty
  property p_irq;       status_q[`SC1_B_RXIRQ] && status_q[`SC1_B_RXIE] |=> rx_irq; endproperty
  property p_start;     tx_ph_q == ph_start |-> !txd; endproperty
  property p_rx_off;    !rx_en |=> rx_ph_q == ph_idle ##1 !rx_end_q; endproperty
  a_tx_rst:    assert property (p_tx_rst) else $error("transmit control reset value wrong");
  a_rx_rst:    assert property (p_rx_rst) else $error("receive control reset value wrong");
  a_stat_rst:  assert property (p_stat_rst) else $error("status reset value wrong");
  a_rx_load:   assert property (p_rx_load) else $error("holding register or request not set");
  a_rx_ignore: assert property (p_rx_ignore) else $error("ignored frame changed holding");
  a_sticky:    assert property (p_sticky) else $error("framing flag dropped by hardware");
  a_overrun:   assert property (p_overrun) else $error("overrun not flagged");
  a_irq:       assert property (p_irq) else $error("receive irq not raised");
  a_start:     assert property (p_start) else $error("start bit not low");
  a_rx_off:    assert property (p_rx_off) else $error("disabled receiver still active");
  c_accept: cover property (rx_accept);
  c_ignore: cover property (rx_end_q && rx_ignore);
  c_tx:     cover property (tx_load ##[1:400] tx_ph_q == ph_stop);
endmodule : serial_channel_one

// [verification/serial_partner.sv]
// remote serial device model: sends frames on rxd, records frames seen on txd
module serial_partner #(
  parameter int BC = 4
) (
  input  wire logic        aclk,
  input  wire logic        txd,
  output logic             rxd,
  output logic [11:0]      got
);
  timeunit 1ns;
  timeprecision 1ns;
  // line idles high, as with a pull-up
  initial rxd = 1'b1;
  // bits leave lsb first; the caller supplies start, marker, parity and stop
  task automatic send(input logic [12:0] f, input int n);
    for (int i = 0; i < n; i++)
      repeat (BC) @(posedge aclk) rxd <= f[i];
    @(posedge aclk) rxd <= 1'b1;
  endtask : send
  // sample mid-bit so that a late start edge still lands inside each bit
  always
  begin
    @(negedge txd);
    repeat (BC / 2 + BC) @(posedge aclk);
    for (int i = 0; i < 12; i++)
    begin
      got[i] <= txd;
      repeat (BC) @(posedge aclk);
    end
  end
endmodule : serial_partner

// [verification/serial_channel_one_test.sv]
// bench for the second serial channel, compared with a bench model
module serial_channel_one_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BC = 4;
  localparam logic [7:0] RST [3] = '{8'h88, 8'h08, 8'h00};
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rxd, txd, unread;
  logic        awready, wready, bvalid, arready, rvalid, sclk_out, sclk_oe_n, rx_irq, tx_irq;
  logic [7:0]  awaddr, araddr, tc, rc, st, hold, d;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, br, rr;
  logic [11:0] got, e, sg;
  int          bad_count, check_count, seed, k;

  serial_channel_one #(.BIT_CYCLES(BC)) dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .rxd, .txd, .sclk_in(1'b0), .sclk_out, .sclk_oe_n, .rx_irq, .tx_irq);
  serial_partner #(.BC(BC)) partner_u (.aclk, .txd, .rxd, .got);

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // hang guard, far above the thousand or so cycles the run needs
  initial
  begin
    repeat (30000) @(posedge aclk);
    bad_count++;
    end_of_test();
  end
  task automatic end_of_test;
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  // each channel drops its valid at its own handshake
  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    awaddr <= a;
    wdata <= {24'h000000, dt};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!bvalid);
    br = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rv = rdata;
    rr = rresp;
  endtask : rd
  // send one frame in the current receive format, then update the model
  task automatic put(input logic [7:0] dt, input logic mk, input logic bp, input logic bs);
    logic [12:0] f;
    f = {4'hF, dt, 1'b0};
    k = 9;
    f[k] = mk;
    k = k + rc[0];
    f[k] = ^dt ^ !rc[6] ^ bp;
    k = k + rc[5];
    f[k] = !bs;
    partner_u.send(f, k + 1);
    repeat (2 * BC) @(posedge aclk);
    if (rc[7] && !(rc[0] && rc[2] && !mk))
    begin
      st = st | {2'b00, 1'b1, 1'b0, rc[0] && !rc[2] && mk, bp && rc[5], unread, bs};
      unread = 1'b1;
      hold = dt;
    end
  endtask : put
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    st = 8'h00;
    unread = 1'b0;
    for (int a = 0; a < 3; a++)
    begin
      rd(8'(a * 4 + a / 2 * 4));
      chk(rv, {24'h000000, RST[a]});
    end
  endtask : do_reset

  initial
  begin
    {aresetn, awvalid, wvalid, arvalid} = 4'h0;
    {bready, rready} = 2'h3;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    seed = 32'h14E0;
    do_reset();
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($random(seed));
      wr(8'h00, d);
      chk(br, 2'h0);
      rd(8'h00);
      chk(rv, {24'h000000, d | 8'h88});
      wr(8'h04, d & 8'h7F);
      rd(8'h04);
      chk(rv, {24'h000000, d & 8'h7F | 8'h08});
    end
    wr(8'h10, 8'hA5);
    chk(br, 2'h2);
    rd(8'h10);
    chk(rv, 32'h00000000);
    chk(rr, 2'h2);
    // a write without the low byte lane must leave the register alone
    wstrb <= 4'hE;
    wr(8'h00, 8'h00);
    wstrb <= 4'hF;
    chk(br, 2'h0);
    rd(8'h00);
    chk(rv, {24'h000000, d | 8'h88});
    wr(8'h0C, 8'h40);
    st = 8'h40;
    // four uart frames, then one frame as synchronous master
    for (int j = 0; j < 5; j++)
    begin
      tc = (8'h75 & 8'($random(seed))) | (j == 4 ? 8'h12 : 8'h00);
      wr(8'h00, tc);
      d = 8'($random(seed));
      wr(8'h08, d);
      e = {4'hF, d};
      k = 8;
      if (tc[0])
        e[k] = tc[2];
      k = k + tc[0];
      if (tc[5])
        e[k] = ^d ^ !tc[6];
      if (j < 4)
      begin
        repeat (16 * BC) @(posedge aclk);
        chk(got, e);
      end
      else
      begin
        // bits read at each rising shift clock, as a slave on the line would
        sg = 12'hFFF;
        for (int b = 0; b < k + tc[5]; b++)
        begin
          @(posedge sclk_out);
          sg[b] = txd;
          chk(sclk_oe_n, 1'b0);
        end
        repeat (4) @(posedge aclk);
        chk(sg, e);
        chk({sclk_out, sclk_oe_n}, 2'h1);
      end
      st[7] = 1'b1;
    end
    rd(8'h0C);
    chk(rv, st);
    chk(tx_irq, 1'b1);
    wr(8'h0C, 8'h10);
    st = 8'h10;
    // normal, parity error, framing, overrun, address error, ignored, disabled
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h04, 8'h00);
      rc = (i < 6 ? 8'h80 : 8'h00) | (8'h60 & 8'($random(seed))) | {2'b00, i == 1, 2'b00, i == 5, 1'b0, i > 3};
      wr(8'h04, rc);
      put(8'($random(seed)), i == 4, i == 1, i == 2);
      rd(8'h0C);
      chk(rv, st);
      chk(rx_irq, st[4] & st[5]);
      if (i == 3)
      begin
        wr(8'h0C, 8'h10);  // flags cleared with the buffer still unread
        st = 8'h10;
      end
      else if (i != 2)
      begin
        rd(8'h08);
        chk(rv, hold);
        unread = 1'b0;
      end
    end
    do_reset();
    end_of_test();
  end
endmodule : serial_channel_one_test
